/* rtl/diee_filter.sv */
// Per-input filter that qualifies edges by a held time in milliseconds.
`timescale 1ns/1ps
`default_nettype none
module diee_filter import diee_pkg::*; #(
	parameter int unsigned FW = FILT_W
) (
	input  wire logic          clock_in,  // System clock.
	input  wire logic          rst_in,    // Asynchronous reset, high.
	input  wire logic          tick_in,   // Millisecond tick pulse.
	input  wire logic          pin_in,    // Synchronised pin level.
	input  wire logic [FW-1:0] filt_in,   // Filter time in ms.
	output logic               level_out, // Qualified level.
	output logic               rise_out,  // Qualified rising pulse.
	output logic               fall_out   // Qualified falling pulse.
);

	logic          level_r;
	logic          prev_r;
	logic [FW-1:0] cnt_r;

	// Tracks raw changes; restart of the count on every new transition.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			prev_r <= 1'b0;
			cnt_r  <= '0;
		end else begin
			prev_r <= pin_in;
			if (pin_in != prev_r) begin
				cnt_r <= '0;
			end else if (tick_in && pin_in != level_r && cnt_r <= filt_in) begin
				// Counts one tick past the filter time, so the held time is
				// never shorter than the programmed time.
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// Accepts the new level once held for the filter time, or at once.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			level_r  <= 1'b0;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end else begin
			rise_out <= 1'b0;
			fall_out <= 1'b0;
			if (pin_in != level_r &&
			    (filt_in == '0 ||
			     (pin_in == prev_r && cnt_r > filt_in))) begin
				level_r  <= pin_in;
				rise_out <= pin_in;
				fall_out <= ~pin_in;
			end
		end
	end

	assign level_out = level_r;

	// Zero filter reports the transition one cycle after the pin moves.
	a_zero_immediate: assert property (@(posedge clock_in) disable iff (rst_in)
		(filt_in == '0 && $stable(filt_in) && pin_in != level_r)
		|=> (level_r == $past(pin_in)))
		else $error("zero filter did not pass the level at once");

	// With a nonzero filter, the level never moves unless the count passed the filter time.
	a_held_time: assert property (@(posedge clock_in) disable iff (rst_in)
		(filt_in != '0 && $stable(filt_in) && pin_in != level_r
		 && cnt_r <= filt_in) |=> $stable(level_r))
		else $error("level changed before the filter time elapsed");

endmodule
`default_nettype wire

/* rtl/diee_pkg.sv */
// Package of constants and types for the debounced digital input block.
// Function
// - Three inputs; a read by index returns one level, else all three.
// - Each input holds a rising action and a falling action, issued on edges; of inputs with edges in one cycle, only the lowest-numbered is issued.
// - Edge event only after input holds new level for the filter time.
// - Filter time zero raises the event at once on the transition.
// - Filter time is 0 to 1000 ms; larger writes are clamped to 1000.
// - Filter times reset to zero.
package diee_pkg;

	// Clock rate and millisecond tick period.
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned TICK_MS      = 1;
	localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

	// Input count, filter width and limits.
	localparam int unsigned NUM_IN       = 3;
	localparam int unsigned FILT_W       = 10;
	localparam logic [9:0]  FILT_MAX     = 10'h3E8;
	localparam logic [9:0]  FILT_RST     = 10'h000;

	// Action code width and reset value.
	localparam int unsigned ACT_W        = 8;
	localparam logic [7:0]  ACT_RST      = 8'h00;

	// Index code that asks for all inputs at once.
	localparam logic [1:0]  IDX_ALL      = 2'h3;

	// One configuration write for one input.
	typedef struct packed {
		logic       wr;
		logic [1:0] idx;
		logic [9:0] filt;
		logic [7:0] act_rise;
		logic [7:0] act_fall;
	} diee_cfg_t;

	// One issued action.
	typedef struct packed {
		logic       valid;
		logic [1:0] idx;
		logic       rising;
		logic [7:0] code;
	} diee_act_t;

endpackage

/* rtl/diee_top.sv */
// Debounced digital inputs with per-edge stored actions.
`timescale 1ns/1ps
`default_nettype none
module diee_top import diee_pkg::*; #(
	parameter int unsigned N  = NUM_IN,
	parameter int unsigned TC = TICK_CYCLES
) (
	input  wire logic        clock_in,   // System clock, 100 MHz.
	input  wire logic        rst_in,     // Asynchronous reset, high.
	input  wire logic [2:0]  pins_in,    // Raw input pins.
	input  wire diee_cfg_t   cfg_in,     // Configuration write.
	input  wire logic [1:0]  rd_idx_in,  // Read index, 3 for all.
	output logic [2:0]       levels_out, // Read levels.
	output diee_act_t        act_out     // Issued action.
);

	////////////////////////////////////////////////////////////////////
	// Millisecond tick divider.
	logic [31:0] div_r;
	logic        tick_r;

	// Counts clock cycles and pulses once per millisecond.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else if (div_r == TC - 1) begin
			div_r  <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 32'h1;
			tick_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;

	// Two flops bring the asynchronous pins into the clock domain.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pins_in;
			sync2_r <= sync1_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration storage.
	logic [FILT_W-1:0] filt_r [N];
	logic [ACT_W-1:0]  rise_act_r [N];
	logic [ACT_W-1:0]  fall_act_r [N];
	logic [2:0]        lvl;
	logic [2:0]        rise;
	logic [2:0]        fall;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_in
			// Stores filter time and actions; out-of-range time is clamped.
			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					filt_r[g]     <= FILT_RST;
					rise_act_r[g] <= ACT_RST;
					fall_act_r[g] <= ACT_RST;
				end else if (cfg_in.wr && cfg_in.idx == 2'(g)) begin
					filt_r[g] <= (cfg_in.filt > FILT_MAX) ?
					             FILT_MAX : cfg_in.filt;
					rise_act_r[g] <= cfg_in.act_rise;
					fall_act_r[g] <= cfg_in.act_fall;
				end
			end

			diee_filter #(.FW(FILT_W)) u_filt (
				.clock_in  (clock_in),
				.rst_in    (rst_in),
				.tick_in   (tick_r),
				.pin_in    (sync2_r[g]),
				.filt_in   (filt_r[g]),
				.level_out (lvl[g]),
				.rise_out  (rise[g]),
				.fall_out  (fall[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Level read and action issue.

	// Returns one level by index or all three together.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			levels_out <= '0;
		end else if (rd_idx_in == IDX_ALL) begin
			levels_out <= lvl;
		end else begin
			levels_out <= {2'b00, lvl[rd_idx_in]};
		end
	end

	// Issues the action of the lowest-numbered input with an edge.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			act_out <= '0;
		end else begin
			act_out <= '0;
			for (int i = N - 1; i >= 0; i--) begin
				if (rise[i] || fall[i]) begin
					act_out.valid  <= 1'b1;
					act_out.idx    <= 2'(i);
					act_out.rising <= rise[i];
					act_out.code   <= rise[i] ? rise_act_r[i] : fall_act_r[i];
				end
			end
		end
	end

	// Every qualified edge of input 0 is issued the next cycle.
	a_edge_issue: assert property (@(posedge clock_in) disable iff (rst_in)
		(rise[0] || fall[0]) |=> (act_out.valid && act_out.idx == 2'h0
		 && act_out.rising == $past(rise[0])))
		else $error("edge of input 0 did not issue its action");

	// Stored filter times of inputs 0 and 1 never exceed the limit.
	a_filt_range: assert property (@(posedge clock_in) disable iff (rst_in)
		filt_r[0] <= FILT_MAX && filt_r[1] <= FILT_MAX)
		else $error("filter time out of range");

	// The tick never comes in two cycles running.
	a_tick_period: assert property (@(posedge clock_in) disable iff (rst_in)
		tick_r |=> !tick_r)
		else $error("millisecond tick too close");

	// Read of all returns all qualified levels.
	a_read_all: assert property (@(posedge clock_in) disable iff (rst_in)
		rd_idx_in == IDX_ALL |=> levels_out == $past(lvl))
		else $error("all-input read wrong");

endmodule
`default_nettype wire

/* sim/diee_pins_model.sv */
// Model of the switches and logic signals on the three input pins.
`timescale 1ns/1ps
`default_nettype none
module diee_pins_model (
	input  wire logic  clock_in, // System clock.
	output logic [2:0] pins_out  // Pin levels.
);
	// Pins start low.
	initial pins_out = 3'h0;
	// Sets one pin to a clean level just after a falling edge.
	task automatic set_pin(input int i, input logic v);
		@(negedge clock_in);
		pins_out[i] = v;
	endtask
	// Makes a pin chatter with n toggles, k cycles apart.
	task automatic chatter(input int i, input int n, input int k);
		repeat (n) begin
			set_pin(i, ~pins_out[i]);
			repeat (k - 1) @(negedge clock_in);
		end
	endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the debounced digital input block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import diee_pkg::*;
	localparam int TCS = 10; // Cycles per tick, shortened.
	logic        clock_in;
	logic        rst_in;
	logic [2:0]  pins;
	logic [1:0]  rd_idx;
	diee_cfg_t   cfg;
	logic [2:0]  levels;
	diee_act_t   act;
	diee_act_t   seen[$];
	logic [13:0] rows[6];
	int          err_total;
	int          total_checks;
	int          cyc;

	diee_pins_model diee_pins_model_inst (.clock_in(clock_in),
		.pins_out(pins));
	diee_top #(.TC(TCS)) diee_top_inst (.clock_in(clock_in),
		.rst_in(rst_in), .pins_in(pins), .cfg_in(cfg),
		.rd_idx_in(rd_idx), .levels_out(levels), .act_out(act));

	////////////////////////////////////////
	// Clock of 10 ns period.
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// Collects issued actions and cuts a hang short.
	always @(negedge clock_in) begin
		cyc++;
		if (act.valid === 1'b1) seen.push_back(act);
		if (cyc == 2000) begin
			err_total++;
			summarize();
		end
	end
	// Compares one value and reports a mismatch.
	task automatic check(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Waits a bounded time for one action and compares it.
	task automatic wait_ev(input int lim, input logic [10:0] exp);
		diee_act_t a;
		repeat (lim) if (seen.size() == 0) @(negedge clock_in);
		a = (seen.size() > 0) ? seen.pop_front() : '0;
		check("action", {1'b1, exp}, {a.valid, a.idx, a.rising, a.code});
	endtask
	// Reads levels; the answer comes one cycle later.
	task automatic rd(input logic [1:0] i, input logic [2:0] exp);
		@(negedge clock_in);
		rd_idx = i;
		@(negedge clock_in);
		check("levels", {9'h000, exp}, {9'h000, levels});
	endtask
	// Writes filter time and actions 10h+i and 20h+i for one input.
	task automatic cfg_wr(input logic [1:0] i, input logic [9:0] f);
		@(negedge clock_in);
		cfg = '{1'b1, i, f, {6'h04, i}, {6'h08, i}};
		@(negedge clock_in);
		cfg.wr = 1'b0;
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	// Rows of pin, level, action code and all levels, then the odd cases.
	initial begin
		rows = '{{2'h0, 1'b1, 8'h10, 3'h1}, {2'h1, 1'b1, 8'h11, 3'h3},
			{2'h2, 1'b1, 8'h12, 3'h7}, {2'h1, 1'b0, 8'h21, 3'h5},
			{2'h0, 1'b0, 8'h20, 3'h4}, {2'h2, 1'b0, 8'h22, 3'h0}};
		cfg = '0;
		rd_idx = 2'h3;
		rst_in = 1'b1;
		repeat (5) @(negedge clock_in);
		rst_in = 1'b0;
		for (int i = 0; i < 3; i++) cfg_wr(2'(i), 10'h000);
		foreach (rows[r]) begin
			diee_pins_model_inst.set_pin(rows[r][13:12], rows[r][11]);
			wait_ev(8, rows[r][13:3]);
			rd(rows[r][13:12], {2'h0, rows[r][11]});
			rd(2'h3, rows[r][2:0]);
		end
		$display("row tests done");
		rst_in = 1'b1;
		@(negedge clock_in);
		check("reset levels", 12'h000, {9'h000, levels});
		rst_in = 1'b0;
		diee_pins_model_inst.set_pin(0, 1'b1);
		wait_ev(8, 11'h100);
		$display("reset test done");
		cfg_wr(2'h1, 10'h002);
		diee_pins_model_inst.chatter(1, 5, 15);
		diee_pins_model_inst.chatter(1, 2, 2);
		repeat (14) @(negedge clock_in);
		check("quiet", 12'h000, {11'h000, seen.size() != 0});
		wait_ev(25, 11'h311);
		$display("filter test done");
		summarize();
	end
endmodule
`default_nettype wire
